// ==== sixteen_bit_timer_counter.sv ====
// Behaviour
// - Control bit 7 selects buffered 16-bit access; clear means two 8-bit accesses.
// - Bits 5:4 pick prescale 1:1, 1:2, 1:4 or 1:8 of the count clock.
// - Control bit 6 is unimplemented and always reads zero.
// - Bit 3 enables the secondary oscillator; clear shuts its amplifier off.
// - With the oscillator enabled both oscillator pins are inputs regardless of direction.
// - Bit 2 disables external clock synchronisation; ignored for the internal source.
// - Bit 1 selects external rising-edge source; clear selects instruction clock.
// - Bit 0 runs the counter; when clear the count holds.
// - Internal source advances once per instruction cycle through the prescaler.
// - External source advances on rising edges of pin or enabled oscillator.
// - Count runs 0000h to FFFFh then wraps to 0000h.
// - Each wrap latches the overflow flag; interrupt only when enabled.
// - Compare special event mode 1011 trigger clears count and starts conversion.
// - A special event clear never sets the overflow flag.
// - A counter write in the trigger cycle wins over the clear.
// - In special event mode the compare pair sets the count period.
// - In 16-bit mode a low byte read snapshots the high byte into buffer.
// - In 16-bit mode a low byte write loads high byte from buffer together.
// - In 16-bit mode the high address reaches only the buffer.
// - Low byte writes clear the prescaler; high buffer writes leave it.
// - Oscillator keeps running during sleep; counting from it continues only with bit 2 set.
//
// Design decisions made here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
module sixteen_bit_timer_counter (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [4:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  input wire logic sleep_i,
  input wire logic external_count_pin_i,
  input wire logic osc_input_pin_i,
  input wire logic [1:0] port_direction_i,
  input wire logic [1:0] port_out_i,
  output logic [1:0] pin_out_o,
  output logic [1:0] pin_oe_n_o,
  output logic osc_amp_enable_o,
  output logic irq_o,
  output logic adc_start_o
);

  timer_counter_pkg::bus_request_type req;
  timer_counter_pkg::control_type control;
  logic [15:0] count;
  logic [7:0] high_buffer;
  logic [15:0] compare_value_pair;
  logic [3:0] compare_unit_mode;
  logic adc_enable;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic [2:0] prescale_count;
  logic ack;
  logic ext_q;
  logic ext_qd;
  logic sync_1;
  logic sync_2;
  logic sync_3;
  logic match_prev;

  logic access;
  logic accept_write;
  logic read_capture;
  logic low_lane;
  logic count_low_write;
  logic count_high_write;
  logic ext_source;
  logic ext_edge;
  logic source_tick;
  logic [2:0] prescale_limit;
  logic prescale_done;
  logic increment;
  logic match;
  logic trigger;
  logic wrap;
  logic flag_clear;

  assign req = '{address: address_i, read: read_i, write: write_i,
                 writedata: writedata_i, byteenable: byteenable_i};

  // Bus slave: one wait cycle per access, read data registered on the first edge
  assign access = (req.read || req.write) && !ack;
  assign waitrequest_o = (req.read || req.write) && !ack;
  assign accept_write = req.write && ack;
  assign read_capture = req.read && !ack;
  assign low_lane = req.byteenable[0];
  assign count_low_write = accept_write && low_lane &&
                           (req.address == timer_counter_pkg::COUNT_LOW_OFFSET);
  assign count_high_write = accept_write && low_lane &&
                            (req.address == timer_counter_pkg::COUNT_HIGH_OFFSET);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack <= 1'b0;
    end else begin
      ack <= access;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      readdata_o <= 32'h00000000;
    end else if (read_capture) begin
      readdata_o <= 32'h00000000;
      unique case (req.address)
        timer_counter_pkg::CONTROL_OFFSET: begin
          readdata_o[7:0] <= {control[7], 1'b0, control[5:0]};
        end
        timer_counter_pkg::COUNT_LOW_OFFSET: begin
          readdata_o[7:0] <= count[7:0];
        end
        timer_counter_pkg::COUNT_HIGH_OFFSET: begin
          if (control.wide_access_enable) begin
            readdata_o[7:0] <= high_buffer;
          end else begin
            readdata_o[7:0] <= count[15:8];
          end
        end
        timer_counter_pkg::FLAG_OFFSET: begin
          readdata_o[timer_counter_pkg::FLAG_BIT] <= overflow_flag;
          readdata_o[timer_counter_pkg::IRQ_ENABLE_BIT] <= overflow_irq_enable;
        end
        timer_counter_pkg::COMPARE_LOW_OFFSET: begin
          readdata_o[7:0] <= compare_value_pair[7:0];
        end
        timer_counter_pkg::COMPARE_HIGH_OFFSET: begin
          readdata_o[7:0] <= compare_value_pair[15:8];
        end
        timer_counter_pkg::COMPARE_MODE_OFFSET: begin
          readdata_o[3:0] <= compare_unit_mode;
          readdata_o[timer_counter_pkg::ADC_ENABLE_BIT] <= adc_enable;
        end
        default: begin
          readdata_o <= 32'h00000000;
        end
      endcase
    end
  end

  // Software registers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      control <= timer_counter_pkg::CONTROL_RESET;
      compare_value_pair <= timer_counter_pkg::COMPARE_RESET;
      compare_unit_mode <= timer_counter_pkg::COMPARE_MODE_RESET;
      adc_enable <= 1'b0;
      overflow_irq_enable <= 1'b0;
    end else if (accept_write && low_lane) begin
      unique case (req.address)
        timer_counter_pkg::CONTROL_OFFSET: begin
          control <= {req.writedata[7], 1'b0, req.writedata[5:0]};
        end
        timer_counter_pkg::FLAG_OFFSET: begin
          overflow_irq_enable <= req.writedata[timer_counter_pkg::IRQ_ENABLE_BIT];
        end
        timer_counter_pkg::COMPARE_LOW_OFFSET: begin
          compare_value_pair[7:0] <= req.writedata[7:0];
        end
        timer_counter_pkg::COMPARE_HIGH_OFFSET: begin
          compare_value_pair[15:8] <= req.writedata[7:0];
        end
        timer_counter_pkg::COMPARE_MODE_OFFSET: begin
          compare_unit_mode <= req.writedata[3:0];
          adc_enable <= req.writedata[timer_counter_pkg::ADC_ENABLE_BIT];
        end
        default: begin
          adc_enable <= adc_enable;
        end
      endcase
    end
  end

  // Oscillator amplifier and pin direction override
  assign osc_amp_enable_o = control.secondary_osc_enable;
  assign pin_out_o = port_out_i;
  assign pin_oe_n_o = control.secondary_osc_enable ? 2'b11 : port_direction_i;

  // External source: oscillator when enabled, else the count pin
  assign ext_source = control.secondary_osc_enable ? osc_input_pin_i
                                                   : external_count_pin_i;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_q <= 1'b0;
      ext_qd <= 1'b0;
    end else begin
      ext_q <= ext_source;
      ext_qd <= ext_q;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_1 <= 1'b0;
      sync_2 <= 1'b0;
      sync_3 <= 1'b0;
    end else begin
      sync_1 <= ext_source;
      sync_2 <= sync_1;
      sync_3 <= sync_2;
    end
  end

  // Synchronised path stops with the instruction clock in sleep; unsynchronised runs on
  always_comb begin
    if (control.external_sync_disable) begin
      ext_edge = ext_q && !ext_qd;
    end else begin
      ext_edge = sync_2 && !sync_3 && !sleep_i;
    end
  end

  assign source_tick = control.count_source_select ? ext_edge : !sleep_i;

  // Prescaler
  always_comb begin
    unique case (control.count_prescale_select)
      timer_counter_pkg::PRESCALE_1: prescale_limit = 3'h0;
      timer_counter_pkg::PRESCALE_2: prescale_limit = 3'h1;
      timer_counter_pkg::PRESCALE_4: prescale_limit = 3'h3;
      timer_counter_pkg::PRESCALE_8: prescale_limit = 3'h7;
    endcase
  end

  // A count left above a newly chosen smaller ratio completes at once instead of wrapping
  assign prescale_done = (prescale_count >= prescale_limit);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prescale_count <= 3'h0;
    end else if (count_low_write) begin
      prescale_count <= 3'h0;
    end else if (control.counter_run && source_tick) begin
      prescale_count <= prescale_done ? 3'h0 : prescale_count + 3'h1;
    end
  end

  assign increment = control.counter_run && source_tick && prescale_done;

  // Special event trigger on a fresh compare match
  assign match = (compare_unit_mode == timer_counter_pkg::SPECIAL_EVENT_MODE) &&
                 (count == compare_value_pair);
  assign trigger = match && !match_prev;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      match_prev <= 1'b0;
    end else begin
      match_prev <= match;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      adc_start_o <= 1'b0;
    end else begin
      adc_start_o <= trigger && adc_enable;
    end
  end

  // A wide-mode high write only touches the buffer, so it must not mask a wrap
  assign wrap = increment && (count == timer_counter_pkg::COUNT_MAX) &&
                !trigger && !count_low_write &&
                !(count_high_write && !control.wide_access_enable);

  // Counter: software write, then trigger clear, then increment
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count <= timer_counter_pkg::COUNT_RESET;
    end else if (count_low_write) begin
      count[7:0] <= req.writedata[7:0];
      if (control.wide_access_enable) begin
        count[15:8] <= high_buffer;
      end
    end else if (count_high_write && !control.wide_access_enable) begin
      count[15:8] <= req.writedata[7:0];
    end else if (trigger) begin
      count <= timer_counter_pkg::COUNT_RESET;
    end else if (increment) begin
      count <= count + 16'h0001;
    end
  end

  // High byte buffer
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      high_buffer <= timer_counter_pkg::BUFFER_RESET;
    end else if (count_high_write && control.wide_access_enable) begin
      high_buffer <= req.writedata[7:0];
    end else if (read_capture && control.wide_access_enable &&
                 (req.address == timer_counter_pkg::COUNT_LOW_OFFSET)) begin
      high_buffer <= count[15:8];
    end
  end

  // Overflow flag, set beats a software clear
  assign flag_clear = accept_write && low_lane &&
                      (req.address == timer_counter_pkg::FLAG_OFFSET) &&
                      !req.writedata[timer_counter_pkg::FLAG_BIT];

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      overflow_flag <= 1'b0;
    end else if (wrap) begin
      overflow_flag <= 1'b1;
    end else if (flag_clear) begin
      overflow_flag <= 1'b0;
    end
  end

  assign irq_o = overflow_flag && overflow_irq_enable;

  // Checks
  a_ctrl_bit_six: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (read_capture && req.address == timer_counter_pkg::CONTROL_OFFSET) |=> !readdata_o[6])
    else $error("control bit 6 read as one");

  a_wrap_sets_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wrap |=> (overflow_flag && count == 16'h0000))
    else $error("wrap did not zero count and set flag");

  a_trigger_clears_count: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (trigger && !count_low_write && !count_high_write) |=> (count == 16'h0000))
    else $error("special event did not clear count");

  a_trigger_no_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (trigger && !overflow_flag) |=> !overflow_flag)
    else $error("special event set overflow flag");

  a_write_beats_trigger: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (count_low_write && trigger) |=> (count[7:0] == $past(req.writedata[7:0])))
    else $error("trigger overrode counter write");

  a_stopped_holds: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!control.counter_run && !count_low_write && !count_high_write && !trigger)
      |=> $stable(count))
    else $error("stopped counter changed");

  a_osc_pins_input: assert property (@(posedge clk_i) disable iff (!rstn_i)
    control.secondary_osc_enable |-> (pin_oe_n_o == 2'b11))
    else $error("oscillator pin driven while oscillator enabled");

  a_irq_masked: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (overflow_flag && !overflow_irq_enable) |-> !irq_o)
    else $error("interrupt raised while disabled");

  a_snapshot_high: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (read_capture && control.wide_access_enable && !count_high_write &&
     req.address == timer_counter_pkg::COUNT_LOW_OFFSET)
      |=> (high_buffer == $past(count[15:8])))
    else $error("low byte read missed high byte snapshot");

  a_prescale_cleared: assert property (@(posedge clk_i) disable iff (!rstn_i)
    count_low_write |=> (prescale_count == 3'h0))
    else $error("low byte write left prescaler count");

  a_timer_steps: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (control.counter_run && !control.count_source_select && !sleep_i &&
     control.count_prescale_select == timer_counter_pkg::PRESCALE_1 && !trigger &&
     !count_low_write && !count_high_write) |=> (count == $past(count) + 16'h0001))
    else $error("timer did not advance each cycle");

  c_overflow: cover property (@(posedge clk_i) disable iff (!rstn_i) wrap);
  c_special_event: cover property (@(posedge clk_i) disable iff (!rstn_i)
    trigger ##1 adc_start_o);
  c_wide_write: cover property (@(posedge clk_i) disable iff (!rstn_i)
    count_low_write && control.wide_access_enable);
  c_external_edge: cover property (@(posedge clk_i) disable iff (!rstn_i)
    control.count_source_select && increment);

endmodule

// ==== timer_counter_pkg.sv ====
package timer_counter_pkg;

  // Register byte addresses on the Avalon-MM slave
  localparam logic [4:0] CONTROL_OFFSET = 5'h00;
  localparam logic [4:0] COUNT_LOW_OFFSET = 5'h04;
  localparam logic [4:0] COUNT_HIGH_OFFSET = 5'h08;
  localparam logic [4:0] FLAG_OFFSET = 5'h0C;
  localparam logic [4:0] COMPARE_LOW_OFFSET = 5'h10;
  localparam logic [4:0] COMPARE_HIGH_OFFSET = 5'h14;
  localparam logic [4:0] COMPARE_MODE_OFFSET = 5'h18;

  // Field positions in the flag register
  localparam int FLAG_BIT = 0;
  localparam int IRQ_ENABLE_BIT = 1;
  // Field position of the converter enable in the compare mode register
  localparam int ADC_ENABLE_BIT = 4;

  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] BUFFER_RESET = 8'h00;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [3:0] COMPARE_MODE_RESET = 4'h0;

  // Count limits and compare mode codes
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [3:0] SPECIAL_EVENT_MODE = 4'hB;

  // Prescale codes
  localparam logic [1:0] PRESCALE_1 = 2'h0;
  localparam logic [1:0] PRESCALE_2 = 2'h1;
  localparam logic [1:0] PRESCALE_4 = 2'h2;
  localparam logic [1:0] PRESCALE_8 = 2'h3;

  typedef struct packed {
    logic wide_access_enable;
    logic unused_bit;
    logic [1:0] count_prescale_select;
    logic secondary_osc_enable;
    logic external_sync_disable;
    logic count_source_select;
    logic counter_run;
  } control_type;

  typedef struct packed {
    logic [4:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } bus_request_type;

endpackage

// ==== tb_sixteen_bit_timer_counter.sv ====
`timescale 1ns/1ns
module tb_sixteen_bit_timer_counter;
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
  } row_type;

  logic clk_i, rstn_i, read_i, write_i, sleep_i, ext_pin, osc_pin;
  logic waitrequest_o, osc_amp_enable_o, irq_o, adc_start_o;
  logic [4:0] address_i;
  logic [31:0] writedata_i, readdata_o, rd;
  logic [3:0] byteenable_i;
  logic [1:0] port_direction_i, port_out_i, pin_out_o, pin_oe_n_o;
  int failures = 0;
  int checked = 0;
  int pulses = 0;
  int p0;
  row_type rows [6];

  sixteen_bit_timer_counter dut (.clk_i(clk_i), .rstn_i(rstn_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .sleep_i(sleep_i), .external_count_pin_i(ext_pin), .osc_input_pin_i(osc_pin),
    .port_direction_i(port_direction_i), .port_out_i(port_out_i), .pin_out_o(pin_out_o),
    .pin_oe_n_o(pin_oe_n_o), .osc_amp_enable_o(osc_amp_enable_o), .irq_o(irq_o),
    .adc_start_o(adc_start_o));

  initial begin
    clk_i = 1'h0;
    forever #50 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (adc_start_o === 1'h1) pulses <= pulses + 1;
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_range(input logic [31:0] got, input logic [31:0] lo,
                             input logic [31:0] hi, input string what);
    checked++;
    if ($isunknown(got) || got < lo || got > hi) begin
      failures++;
      $display("[FAIL] %0t %s got %h outside %h..%h", $time, what, got, lo, hi);
    end
  endtask

  // One Avalon request; held until waitrequest is sampled low at a rising edge
  task automatic bus_access(input logic [4:0] addr, input logic wr, input logic [7:0] data,
                            input logic [3:0] be);
    int guard = 0;
    @(posedge clk_i);
    address_i <= addr;
    read_i <= ~wr;
    write_i <= wr;
    writedata_i <= {24'h000000, data};
    byteenable_i <= be;
    do begin
      @(posedge clk_i);
      guard++;
    end while (waitrequest_o !== 1'h0 && guard < 50);
    if (guard >= 50) check(32'h1, 32'h0, "waitrequest never fell");
    rd = readdata_o;
    read_i <= 1'h0;
    write_i <= 1'h0;
    // Return mid-cycle so outputs launched by the accepting edge have settled
    @(negedge clk_i);
  endtask

  task automatic wr(input logic [4:0] addr, input logic [7:0] data);
    bus_access(addr, 1'h1, data, 4'hF);
  endtask

  task automatic rd_check(input logic [4:0] addr, input logic [7:0] exp, input string what);
    bus_access(addr, 1'h0, 8'h00, 4'hF);
    check(rd, {24'h000000, exp}, what);
  endtask

  task automatic pulse_pin(input int n, input logic use_osc);
    repeat (n) begin
      repeat (3) @(posedge clk_i);
      if (use_osc) osc_pin <= 1'h1;
      else ext_pin <= 1'h1;
      repeat (3) @(posedge clk_i);
      if (use_osc) osc_pin <= 1'h0;
      else ext_pin <= 1'h0;
    end
    repeat (8) @(posedge clk_i);
  endtask

  // Clear the count, run on the given source for n edges, then read the count back
  task automatic run_edges(input logic [7:0] ctrl, input int n, input logic use_osc);
    wr(timer_counter_pkg::CONTROL_OFFSET, ctrl & 8'hFE);
    wr(timer_counter_pkg::COUNT_HIGH_OFFSET, 8'h00);
    wr(timer_counter_pkg::COUNT_LOW_OFFSET, 8'h00);
    wr(timer_counter_pkg::CONTROL_OFFSET, ctrl);
    pulse_pin(n, use_osc);
    wr(timer_counter_pkg::CONTROL_OFFSET, ctrl & 8'hFE);
    rd_check(timer_counter_pkg::COUNT_LOW_OFFSET, n[7:0], "edge count");
  endtask

  initial begin
    #(100 * 20000);
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end

  initial begin
    rstn_i = 1'h0;
    {read_i, write_i, sleep_i, ext_pin, osc_pin} = 5'h00;
    address_i = 5'h00;
    writedata_i = 32'h00000000;
    byteenable_i = 4'h0;
    port_direction_i = 2'h0;
    port_out_i = 2'h2;
    rows[0] = '{timer_counter_pkg::CONTROL_OFFSET, 8'hF6, 8'hB6};
    rows[1] = '{timer_counter_pkg::COMPARE_LOW_OFFSET, 8'hA5, 8'hA5};
    rows[2] = '{timer_counter_pkg::COMPARE_HIGH_OFFSET, 8'h5A, 8'h5A};
    rows[3] = '{timer_counter_pkg::COMPARE_MODE_OFFSET, 8'h1B, 8'h1B};
    rows[4] = '{timer_counter_pkg::FLAG_OFFSET, 8'h02, 8'h02};
    rows[5] = '{5'h1C, 8'h77, 8'h00};
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'h1;
    rd_check(timer_counter_pkg::CONTROL_OFFSET, 8'h00, "control reset");
    rd_check(timer_counter_pkg::COUNT_LOW_OFFSET, 8'h00, "count reset");
    check({31'h0, irq_o}, 32'h0, "irq after reset");
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd_check(rows[i].addr, rows[i].rdata, "register row");
    end
    bus_access(timer_counter_pkg::COMPARE_LOW_OFFSET, 1'h1, 8'h11, 4'h0);
    rd_check(timer_counter_pkg::COMPARE_LOW_OFFSET, 8'hA5, "byteenable off write");
    wr(timer_counter_pkg::COMPARE_MODE_OFFSET, 8'h00);
    wr(timer_counter_pkg::FLAG_OFFSET, 8'h00);
    wr(timer_counter_pkg::CONTROL_OFFSET, 8'h08);
    check({30'h0, pin_oe_n_o}, 32'h3, "pins forced to input");
    check({31'h0, osc_amp_enable_o}, 32'h1, "oscillator on");
    check({30'h0, pin_out_o}, 32'h2, "pin data");
    wr(timer_counter_pkg::CONTROL_OFFSET, 8'h00);
    check({30'h0, pin_oe_n_o}, 32'h0, "pins follow direction");
    check({31'h0, osc_amp_enable_o}, 32'h0, "oscillator off");
    for (int ps = 0; ps < 4; ps++) begin
      wr(timer_counter_pkg::CONTROL_OFFSET, {2'h0, ps[1:0], 4'h0});
      wr(timer_counter_pkg::COUNT_LOW_OFFSET, 8'h00);
      wr(timer_counter_pkg::CONTROL_OFFSET, {2'h0, ps[1:0], 4'h1});
      repeat (128) @(posedge clk_i);
      wr(timer_counter_pkg::CONTROL_OFFSET, {2'h0, ps[1:0], 4'h0});
      bus_access(timer_counter_pkg::COUNT_LOW_OFFSET, 1'h0, 8'h00, 4'hF);
      check_range(rd, 32'd128 >> ps, (32'd128 >> ps) + 32'd4, "prescaled count");
    end
    p0 = rd;
    repeat (20) @(posedge clk_i);
    rd_check(timer_counter_pkg::COUNT_LOW_OFFSET, p0[7:0], "stopped count holds");
    wr(timer_counter_pkg::COUNT_HIGH_OFFSET, 8'hFF);
    wr(timer_counter_pkg::COUNT_LOW_OFFSET, 8'hFE);
    wr(timer_counter_pkg::CONTROL_OFFSET, 8'h01);
    repeat (10) @(posedge clk_i);
    wr(timer_counter_pkg::CONTROL_OFFSET, 8'h00);
    bus_access(timer_counter_pkg::COUNT_LOW_OFFSET, 1'h0, 8'h00, 4'hF);
    check_range(rd, 32'h1, 32'h10, "count after wrap");
    rd_check(timer_counter_pkg::COUNT_HIGH_OFFSET, 8'h00, "high byte wrapped");
    rd_check(timer_counter_pkg::FLAG_OFFSET, 8'h01, "overflow latched");
    check({31'h0, irq_o}, 32'h0, "irq masked");
    wr(timer_counter_pkg::FLAG_OFFSET, 8'h03);
    check({31'h0, irq_o}, 32'h1, "irq enabled");
    wr(timer_counter_pkg::FLAG_OFFSET, 8'h02);
    check({31'h0, irq_o}, 32'h0, "irq after clear");
    rd_check(timer_counter_pkg::FLAG_OFFSET, 8'h02, "flag cleared");
    wr(timer_counter_pkg::CONTROL_OFFSET, 8'h80);
    wr(timer_counter_pkg::COUNT_HIGH_OFFSET, 8'h12);
    wr(timer_counter_pkg::COUNT_LOW_OFFSET, 8'h34);
    rd_check(timer_counter_pkg::COUNT_LOW_OFFSET, 8'h34, "wide low");
    rd_check(timer_counter_pkg::COUNT_HIGH_OFFSET, 8'h12, "wide snapshot");
    wr(timer_counter_pkg::COUNT_HIGH_OFFSET, 8'h56);
    rd_check(timer_counter_pkg::COUNT_HIGH_OFFSET, 8'h56, "buffer only");
    wr(timer_counter_pkg::CONTROL_OFFSET, 8'h00);
    rd_check(timer_counter_pkg::COUNT_HIGH_OFFSET, 8'h12, "live high untouched");
    wr(timer_counter_pkg::COUNT_HIGH_OFFSET, 8'h9C);
    wr(timer_counter_pkg::CONTROL_OFFSET, 8'h80);
    rd_check(timer_counter_pkg::COUNT_LOW_OFFSET, 8'h34, "wide low again");
    rd_check(timer_counter_pkg::COUNT_HIGH_OFFSET, 8'h9C, "snapshot of direct write");
    wr(timer_counter_pkg::CONTROL_OFFSET, 8'h00);
    wr(timer_counter_pkg::FLAG_OFFSET, 8'h00);
    wr(timer_counter_pkg::COUNT_HIGH_OFFSET, 8'h00);
    wr(timer_counter_pkg::COUNT_LOW_OFFSET, 8'h00);
    wr(timer_counter_pkg::COMPARE_LOW_OFFSET, 8'h10);
    wr(timer_counter_pkg::COMPARE_HIGH_OFFSET, 8'h00);
    wr(timer_counter_pkg::COMPARE_MODE_OFFSET, 8'h1B);
    p0 = pulses;
    wr(timer_counter_pkg::CONTROL_OFFSET, 8'h01);
    repeat (100) @(posedge clk_i);
    wr(timer_counter_pkg::CONTROL_OFFSET, 8'h00);
    bus_access(timer_counter_pkg::COUNT_LOW_OFFSET, 1'h0, 8'h00, 4'hF);
    check_range(rd, 32'h0, 32'h10, "count bounded by compare");
    check_range(pulses - p0, 32'd4, 32'd7, "conversion starts");
    rd_check(timer_counter_pkg::FLAG_OFFSET, 8'h00, "trigger sets no flag");
    // Count reaches the compare value exactly when the low byte write lands
    wr(timer_counter_pkg::COUNT_LOW_OFFSET, 8'h0E);
    wr(timer_counter_pkg::CONTROL_OFFSET, 8'h01);
    wr(timer_counter_pkg::COUNT_LOW_OFFSET, 8'h55);
    wr(timer_counter_pkg::CONTROL_OFFSET, 8'h00);
    bus_access(timer_counter_pkg::COUNT_LOW_OFFSET, 1'h0, 8'h00, 4'hF);
    check_range(rd, 32'h55, 32'h5A, "write wins over trigger");
    wr(timer_counter_pkg::COMPARE_MODE_OFFSET, 8'h00);
    run_edges(8'h03, 5, 1'h0);
    run_edges(8'h07, 4, 1'h0);
    run_edges(8'h0B, 3, 1'h1);
    @(posedge clk_i);
    sleep_i <= 1'h1;
    run_edges(8'h0F, 3, 1'h1);
    @(posedge clk_i);
    sleep_i <= 1'h0;
    test_done();
  end
endmodule
